// File: design/tcs_top.sv
// tcs_top: control, slave-mode and master-output logic of a 16-bit timer
// assumes counter, prescaler and channels sit beside it on hclk and that
// every trigger and event input is already synchronous to hclk
`timescale 1ns/1ps
module tcs_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  internal_trigger,
  input  wire logic        input_one_edge_detector,
  input  wire logic        filtered_input_one,
  input  wire logic        filtered_input_two,
  input  wire logic        software_update_request,
  input  wire logic        counter_overflow,
  input  wire logic        channel_one_match,
  input  wire logic        channel_two_match,
  input  wire logic        channel_one_output_reference,
  input  wire logic        channel_two_output_reference,
  input  wire logic        core_halted,
  input  wire logic        debug_halt_freeze,
  output logic             internal_count_enable,
  output logic             count_tick,
  output logic             counter_reinit,
  output logic             update_event,
  output logic             reload_buffer_enable,
  output logic             filter_sample_tick,
  output logic             update_irq_req,
  output logic             channel_one_irq_req,
  output logic             channel_two_irq_req,
  output logic             trigger_flag_set,
  output logic             trigger_irq_req,
  output logic             trigger_output
);
  logic [15:0] ctl1_ff, nxt_ctl1, ctl2_ff, nxt_ctl2;
  logic [15:0] smc_ff, nxt_smc, ien_ff, nxt_ien;
  logic [7:0]  addr_ff, nxt_addr;
  logic        wr_ff, nxt_wr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        trig_q_ff, nxt_trig_q, trig_d_ff, nxt_trig_d;
  logic        trig_prev_ff, nxt_trig_prev;
  logic [1:0]  div_ff, nxt_div;
  logic        ice_ff, tick_ff, reinit_ff, upd_ff, rbuf_ff, fst_ff;
  logic        uirq_ff, c1irq_ff, c2irq_ff, tflag_ff, tirq_ff, tout_ff;
  logic        trig_reinit_ff, nxt_trig_reinit;
  logic        acc, wr_ok, trig, trig_rise, slave_on, ice_c, tick_c;
  logic        reinit_c, upd_c, uirq_c, tflag_c, tout_c, fst_c, start_c;
  logic [2:0]  smode, mout;
  logic [1:0]  fdiv;

  // local copies of the field positions used as bit indices
  localparam int RUN_EN_B = tcs_pkg::RUN_EN_B;
  localparam int SMODE_LO = tcs_pkg::SMODE_LO;
  localparam int MOUT_LO = tcs_pkg::MOUT_LO;
  localparam int FDIV_LO = tcs_pkg::FDIV_LO;

  // trigger source multiplexer
  function automatic logic tcs_sel_trig(input logic [2:0] tsel,
                                        input logic [3:0] itr,
                                        input logic ed,
                                        input logic f1,
                                        input logic f2);
    logic r;
    r = 1'b0;
    case (tsel)
      3'h4: r = ed;
      3'h5: r = f1;
      3'h6: r = f2;
      3'h7: r = 1'b0;
      default: r = itr[tsel[1:0]];
    endcase
    return r;
  endfunction

  assign smode = smc_ff[SMODE_LO +: 3];
  assign mout = ctl2_ff[MOUT_LO +: 3];
  assign fdiv = ctl1_ff[FDIV_LO +: 2];
  assign acc = hsel & hready & htrans[1];
  // halfword writes must target the low half of the word
  assign wr_ok = (hsize == tcs_pkg::HSIZE_WORD) |
                 (hsize == tcs_pkg::HSIZE_HALF & ~haddr[1]);

  // bus address phase capture and register writes
  always_comb begin
    nxt_addr = addr_ff;
    nxt_wr = 1'b0;
    nxt_rdata = 32'h0000_0000;
    nxt_ctl1 = ctl1_ff;
    nxt_ctl2 = ctl2_ff;
    nxt_smc = smc_ff;
    nxt_ien = ien_ff;
    if (acc) begin
      nxt_addr = {haddr[7:2], 2'h0};
      nxt_wr = hwrite & wr_ok; // byte writes dropped
      if (!hwrite) begin
        case ({haddr[7:2], 2'h0})
          tcs_pkg::OFF_CTL1: nxt_rdata = {16'h0000, ctl1_ff};
          tcs_pkg::OFF_CTL2: nxt_rdata = {16'h0000, ctl2_ff};
          tcs_pkg::OFF_SMC:  nxt_rdata = {16'h0000, smc_ff};
          tcs_pkg::OFF_IEN:  nxt_rdata = {16'h0000, ien_ff};
          default:           nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_ff) begin
      case (addr_ff)
        tcs_pkg::OFF_CTL1: nxt_ctl1 = hwdata[15:0] & tcs_pkg::MSK_CTL1;
        tcs_pkg::OFF_CTL2: nxt_ctl2 = hwdata[15:0] & tcs_pkg::MSK_CTL2;
        tcs_pkg::OFF_SMC:  nxt_smc = hwdata[15:0] & tcs_pkg::MSK_SMC;
        tcs_pkg::OFF_IEN:  nxt_ien = hwdata[15:0] & tcs_pkg::MSK_IEN;
        default:           nxt_ctl1 = nxt_ctl1;
      endcase
    end
    // single pulse clears run enable on update
    if (upd_c & ctl1_ff[tcs_pkg::PULSE_B]) begin
      nxt_ctl1[RUN_EN_B] = 1'b0;
    end
    // trigger start sets run enable and wins over clears
    if (start_c) begin
      nxt_ctl1[RUN_EN_B] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 8'h00;
      wr_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      ctl1_ff <= tcs_pkg::RST_REG;
      ctl2_ff <= tcs_pkg::RST_REG;
      smc_ff <= tcs_pkg::RST_REG;
      ien_ff <= tcs_pkg::RST_REG;
    end else begin
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      rdata_ff <= nxt_rdata;
      ctl1_ff <= nxt_ctl1;
      ctl2_ff <= nxt_ctl2;
      smc_ff <= nxt_smc;
      ien_ff <= nxt_ien;
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0;     // always okay

  // trigger input path with optional master/slave delay stage
  always_comb begin
    nxt_trig_q = tcs_sel_trig(smc_ff[tcs_pkg::TSRC_LO +: 3],
                              internal_trigger, input_one_edge_detector,
                              filtered_input_one,
                              filtered_input_two);
    nxt_trig_d = trig_q_ff;
    nxt_trig_prev = trig;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_q_ff <= 1'b0;
      trig_d_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else begin
      trig_q_ff <= nxt_trig_q;
      trig_d_ff <= nxt_trig_d;
      trig_prev_ff <= nxt_trig_prev;
    end
  end

  // delayed trigger holds back own effect and trigger out by one more cycle
  assign trig = smc_ff[tcs_pkg::MSDLY_B] ? trig_d_ff : trig_q_ff;
  assign trig_rise = trig & ~trig_prev_ff;
  assign slave_on = smode[2];

  // slave mode controller and event generation
  always_comb begin
    // gated mode ands run enable with trigger level
    ice_c = ctl1_ff[RUN_EN_B] & ((smode != tcs_pkg::SMODE_GATED) | trig);
    tick_c = ice_c & ~(core_halted & debug_halt_freeze);
    if (smode == tcs_pkg::SMODE_EXT) begin
      tick_c = tick_c & trig_rise;
    end
    start_c = (smode == tcs_pkg::SMODE_TRIG) & trig_rise;
    // a trigger-driven reinit is kept one cycle for the master output
    nxt_trig_reinit = (smode == tcs_pkg::SMODE_RESET) & trig_rise;
    reinit_c = software_update_request |
               nxt_trig_reinit;
    upd_c = ~ctl1_ff[tcs_pkg::UPD_DIS_B] &
            (counter_overflow | reinit_c);
    uirq_c = upd_c & ien_ff[tcs_pkg::UPD_IE_B] &
             (counter_overflow | ~ctl1_ff[tcs_pkg::UPD_SRC_B]);
    tflag_c = (smode == tcs_pkg::SMODE_GATED) ? (ice_c ^ ice_ff) :
              (slave_on & trig_rise);
    // trigger-driven reinit reaches the output a cycle after the reinit
    case (mout)
      tcs_pkg::MOUT_RESET: tout_c = software_update_request |
                                    trig_reinit_ff;
      tcs_pkg::MOUT_EN:    tout_c = ice_c;
      tcs_pkg::MOUT_UPD:   tout_c = upd_c;
      tcs_pkg::MOUT_PULSE: tout_c = channel_one_match;
      tcs_pkg::MOUT_REF1:  tout_c = channel_one_output_reference;
      tcs_pkg::MOUT_REF2:  tout_c = channel_two_output_reference;
      default:             tout_c = 1'b0;
    endcase
  end

  // filter sample period divider
  always_comb begin
    nxt_div = div_ff + 2'h1;
    case (fdiv)
      tcs_pkg::FDIV_2: fst_c = div_ff[0];
      tcs_pkg::FDIV_4: fst_c = (div_ff == 2'h3);
      default:           fst_c = 1'b1;
    endcase
  end

  // registered outputs, each one cycle after its cause, except a trigger-driven reinit on trigger_output, which comes two cycles after
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 2'h0;
      ice_ff <= 1'b0;
      tick_ff <= 1'b0;
      reinit_ff <= 1'b0;
      upd_ff <= 1'b0;
      rbuf_ff <= 1'b0;
      trig_reinit_ff <= 1'b0;
      fst_ff <= 1'b0;
      uirq_ff <= 1'b0;
      c1irq_ff <= 1'b0;
      c2irq_ff <= 1'b0;
      tflag_ff <= 1'b0;
      tirq_ff <= 1'b0;
      tout_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      ice_ff <= ice_c;
      tick_ff <= tick_c;
      reinit_ff <= reinit_c;
      upd_ff <= upd_c;
      rbuf_ff <= ctl1_ff[tcs_pkg::RELOAD_BUF_B];
      trig_reinit_ff <= nxt_trig_reinit;
      fst_ff <= fst_c;
      uirq_ff <= uirq_c;
      c1irq_ff <= channel_one_match & ien_ff[tcs_pkg::C1IE_B];
      c2irq_ff <= channel_two_match & ien_ff[tcs_pkg::C2IE_B];
      tflag_ff <= tflag_c;
      tirq_ff <= tflag_c & ien_ff[tcs_pkg::TRG_IE_B];
      tout_ff <= tout_c;
    end
  end

  assign internal_count_enable = ice_ff;
  assign count_tick = tick_ff;
  assign counter_reinit = reinit_ff;
  assign update_event = upd_ff;
  assign reload_buffer_enable = rbuf_ff;
  assign filter_sample_tick = fst_ff;
  assign update_irq_req = uirq_ff;
  assign channel_one_irq_req = c1irq_ff;
  assign channel_two_irq_req = c2irq_ff;
  assign trigger_flag_set = tflag_ff;
  assign trigger_irq_req = tirq_ff;
  assign trigger_output = tout_ff;

  // checks of the control behaviour
  a_byte_write_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    acc & hwrite & (hsize == 3'h0) ##1 1'b1 |=> $stable(ctl2_ff))
    else $error("byte write changed a register");
  a_pulse_stop_run: assert property (@(posedge hclk) disable iff (!hresetn)
    upd_c & ctl1_ff[tcs_pkg::PULSE_B] & ~start_c |=> ~ctl1_ff[RUN_EN_B])
    else $error("single pulse did not stop the counter");
  a_upd_dis_block: assert property (@(posedge hclk) disable iff (!hresetn)
    ctl1_ff[tcs_pkg::UPD_DIS_B] |=> ~update_event)
    else $error("update event while updates disabled");
  a_upd_src_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    ctl1_ff[tcs_pkg::UPD_SRC_B] & ~counter_overflow |=> ~update_irq_req)
    else $error("update irq from software with source bit set");
  a_tout_update: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ($past(mout) == tcs_pkg::MOUT_UPD) |-> trigger_output == update_event)
    else $error("trigger output does not follow update");
  a_gated_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    (smode == tcs_pkg::SMODE_GATED) & ~trig |=> ~internal_count_enable)
    else $error("gated counter runs with trigger low");
  a_ext_clk_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (smode == tcs_pkg::SMODE_EXT) ##1 count_tick |-> $past(trig_rise))
    else $error("external clock tick without trigger edge");
  a_reset_reinit: assert property (@(posedge hclk) disable iff (!hresetn)
    (smode == tcs_pkg::SMODE_RESET) & trig_rise |=> counter_reinit)
    else $error("reset mode edge did not reinit");
  a_debug_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
    core_halted & debug_halt_freeze |=> ~count_tick)
    else $error("counter ticked during frozen debug halt");
  a_div2_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    (fdiv == tcs_pkg::FDIV_2) [*3] ##0 filter_sample_tick
    |=> ~filter_sample_tick)
    else $error("filter tick too close at divide by two");

  // checks of the slave side and of the interrupt gating
  // trigger reinit shows on the master output one cycle after the reinit
  a_tout_delayed: assert property (@(posedge hclk) disable iff (!hresetn)
    (smode == tcs_pkg::SMODE_RESET) & trig_rise &
    (mout == tcs_pkg::MOUT_RESET) ##1 (mout == tcs_pkg::MOUT_RESET)
    |=> trigger_output)
    else $error("trigger output missed the delayed reinit");
  a_start_run: assert property (@(posedge hclk) disable iff (!hresetn)
    start_c |=> ctl1_ff[RUN_EN_B])
    else $error("trigger edge did not start the counter");
  a_trig_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    ~ien_ff[tcs_pkg::TRG_IE_B] |=> ~trigger_irq_req)
    else $error("trigger irq while its enable is clear");
  a_gated_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (smode == tcs_pkg::SMODE_GATED) & (ice_c != ice_ff)
    |=> trigger_flag_set)
    else $error("gated start or stop did not set the trigger flag");
endmodule

// File: shared/tcs_pkg.sv
// tcs_pkg: register map, field positions and codes of the timer control
// block; assumes a 32-bit AHB-Lite bus with word-aligned registers
package tcs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTL1 = 8'h00;
  localparam logic [7:0] OFF_CTL2 = 8'h04;
  localparam logic [7:0] OFF_SMC  = 8'h08;
  localparam logic [7:0] OFF_IEN  = 8'h0c;
  // reset values
  localparam logic [15:0] RST_REG = 16'h0000;
  // writable bits of each register
  localparam logic [15:0] MSK_CTL1 = 16'h038f;
  localparam logic [15:0] MSK_CTL2 = 16'h0070;
  localparam logic [15:0] MSK_SMC  = 16'h00f7;
  localparam logic [15:0] MSK_IEN  = 16'h0047;
  // timer_control_one fields
  localparam int RUN_EN_B = 0;
  localparam int UPD_DIS_B = 1;
  localparam int UPD_SRC_B = 2;
  localparam int PULSE_B = 3;
  localparam int RELOAD_BUF_B = 7;
  localparam int FDIV_LO = 8;
  // timer_control_two and slave_mode_control fields
  localparam int MOUT_LO = 4;
  localparam int SMODE_LO = 0;
  localparam int TSRC_LO = 4;
  localparam int MSDLY_B = 7;
  // interrupt_enables fields
  localparam int UPD_IE_B = 0;
  localparam int C1IE_B = 1;
  localparam int C2IE_B = 2;
  localparam int TRG_IE_B = 6;
  // master output codes
  localparam logic [2:0] MOUT_RESET = 3'h0;
  localparam logic [2:0] MOUT_EN    = 3'h1;
  localparam logic [2:0] MOUT_UPD   = 3'h2;
  localparam logic [2:0] MOUT_PULSE = 3'h3;
  localparam logic [2:0] MOUT_REF1  = 3'h4;
  localparam logic [2:0] MOUT_REF2  = 3'h5;
  // slave mode codes
  localparam logic [2:0] SMODE_OFF   = 3'h0;
  localparam logic [2:0] SMODE_RESET = 3'h4;
  localparam logic [2:0] SMODE_GATED = 3'h5;
  localparam logic [2:0] SMODE_TRIG  = 3'h6;
  localparam logic [2:0] SMODE_EXT   = 3'h7;
  // filter clock division codes
  localparam logic [1:0] FDIV_2 = 2'h1;
  localparam logic [1:0] FDIV_4 = 2'h2;
  // ahb codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// File: testbench/tcs_peer_timer.sv
// tcs_peer_timer: neighbouring timer that raises internal trigger zero
// assumes it shares hclk and the active-low reset with the block
`timescale 1ns/1ps
module tcs_peer_timer (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       fire,
  output logic      [3:0] internal_trigger
);
  logic [3:0] nxt_trig;
  // trigger zero follows the fire request, other timers stay quiet
  always_comb nxt_trig = {3'h0, fire};
  // launched from a flop, as a real master timer output would be
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) internal_trigger <= 4'h0;
    else internal_trigger <= nxt_trig;
  end
endmodule

// File: testbench/timer_control_and_slave_sync_bench.sv
// timer_control_and_slave_sync_bench: self-checking bench of tcs_top
// assumes one AHB-Lite master on a 200 MHz hclk and a peer timer model
`timescale 1ns/1ps
module timer_control_and_slave_sync_bench;
  typedef struct {
    string       nm;
    logic [15:0] c1, c2, sm, ie;
    logic [1:0]  dbg;
    int          sel, obs, exp;
  } tcs_row_t;
  localparam logic [2:0]  W = tcs_pkg::HSIZE_WORD;
  localparam logic [15:0] msk [4] = '{tcs_pkg::MSK_CTL1, tcs_pkg::MSK_CTL2,
                                      tcs_pkg::MSK_SMC, tcs_pkg::MSK_IEN};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [1:0]  dbg = 2'h0;   // core halted, freeze bit
  logic [10:0] pls = 11'h0;  // event and trigger stimulus, by sel
  logic [3:0]  itr;
  logic [11:0] obs;          // design outputs, by obs index
  int          bad_count = 0;
  int          samples_checked = 0;
  int          first;
  int          hits;
  int          lat0;
  // sel: 0 upd req, 1 ovf, 2/3 match, 4/5 ref, 6 peer, 7 none, 8..10 inputs
  // obs: 0 trg out, 1 upd, 2..5 irqs, 6 flag, 7 reinit, 8 en, 9 tick
  tcs_row_t rows [32] = '{
    '{"mout0",16'h0,16'h0,16'h0,16'h0,2'h0,0,0,1},
    '{"mout1",16'h1,16'h10,16'h0,16'h0,2'h0,7,0,8},
    '{"mout2",16'h0,16'h20,16'h0,16'h0,2'h0,1,0,1},
    '{"updoff",16'h2,16'h20,16'h0,16'h0,2'h0,1,0,0},
    '{"updoff_req",16'h2,16'h0,16'h0,16'h0,2'h0,0,7,1},
    '{"mout3",16'h0,16'h30,16'h0,16'h0,2'h0,2,0,1},
    '{"mout4",16'h0,16'h40,16'h0,16'h0,2'h0,4,0,1},
    '{"mout5",16'h0,16'h50,16'h0,16'h0,2'h0,5,0,1},
    '{"mout6",16'h0,16'h60,16'h0,16'h0,2'h0,4,0,0},
    '{"src0",16'h0,16'h0,16'h0,16'h1,2'h0,0,2,1},
    '{"src1_req",16'h4,16'h0,16'h0,16'h1,2'h0,0,2,0},
    '{"src1_ovf",16'h4,16'h0,16'h0,16'h1,2'h0,1,2,1},
    '{"uirq_off",16'h0,16'h0,16'h0,16'h0,2'h0,1,2,0},
    '{"c1irq",16'h0,16'h0,16'h0,16'h2,2'h0,2,3,1},
    '{"c2irq",16'h0,16'h0,16'h0,16'h4,2'h0,3,4,1},
    '{"fdiv0",16'h0,16'h0,16'h0,16'h0,2'h0,7,11,8},
    '{"fdiv1",16'h100,16'h0,16'h0,16'h0,2'h0,7,11,4},
    '{"fdiv2",16'h200,16'h0,16'h0,16'h0,2'h0,7,11,2},
    '{"rbuf",16'h80,16'h0,16'h0,16'h0,2'h0,7,10,8},
    '{"dbg_run",16'h1,16'h0,16'h0,16'h0,2'h2,7,9,8},
    '{"dbg_frz",16'h1,16'h0,16'h0,16'h0,2'h3,7,9,0},
    '{"rst_mode",16'h0,16'h0,16'h4,16'h40,2'h0,6,7,1},
    '{"tflag",16'h0,16'h0,16'h4,16'h40,2'h0,6,5,1},
    '{"mout0_trg",16'h0,16'h0,16'h4,16'h0,2'h0,6,0,1},
    '{"tsel_itr1",16'h0,16'h0,16'h14,16'h0,2'h0,6,7,0},
    '{"tsel_ed",16'h0,16'h0,16'h44,16'h0,2'h0,10,7,1},
    '{"tsel_f1",16'h0,16'h0,16'h54,16'h0,2'h0,8,7,1},
    '{"tsel_f2",16'h0,16'h0,16'h64,16'h0,2'h0,9,7,1},
    '{"gated",16'h1,16'h0,16'h5,16'h0,2'h0,6,6,1},
    '{"gated_off",16'h0,16'h0,16'h5,16'h0,2'h0,6,8,0},
    '{"ext",16'h1,16'h0,16'h7,16'h0,2'h0,6,9,1},
    '{"pulse",16'h9,16'h0,16'h0,16'h0,2'h0,1,1,1}
  };

  // block under test, its single slave answer is the bus ready
  tcs_top i_tcs_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .internal_trigger(itr), .input_one_edge_detector(pls[10]),
    .filtered_input_one(pls[8]), .filtered_input_two(pls[9]),
    .software_update_request(pls[0]), .counter_overflow(pls[1]),
    .channel_one_match(pls[2]), .channel_two_match(pls[3]),
    .channel_one_output_reference(pls[4]),
    .channel_two_output_reference(pls[5]),
    .core_halted(dbg[1]), .debug_halt_freeze(dbg[0]),
    .internal_count_enable(obs[8]), .count_tick(obs[9]),
    .counter_reinit(obs[7]), .update_event(obs[1]),
    .reload_buffer_enable(obs[10]), .filter_sample_tick(obs[11]),
    .update_irq_req(obs[2]), .channel_one_irq_req(obs[3]),
    .channel_two_irq_req(obs[4]), .trigger_flag_set(obs[6]),
    .trigger_irq_req(obs[5]), .trigger_output(obs[0]));
  tcs_peer_timer i_tcs_peer_timer (
    .hclk(hclk), .hresetn(hresetn), .fire(pls[6]), .internal_trigger(itr));

  // 5 ns clock
  initial begin
    forever #2.5 hclk = ~hclk;
  end

  // hang guard, far beyond the expected run length
  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    $display("FAIL watchdog expected done seen timeout");
    end_sim();
  end

  // one single AHB-Lite transfer, read data taken at the data-phase edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= tcs_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // program all registers, apply stimulus, count output highs in 8 cycles
  task automatic run_row(input tcs_row_t r);
    dbg <= r.dbg;
    xfer(1'b1, tcs_pkg::OFF_SMC, 32'h0, W);
    xfer(1'b1, tcs_pkg::OFF_CTL1, {16'h0, r.c1}, W);
    xfer(1'b1, tcs_pkg::OFF_CTL2, {16'h0, r.c2}, W);
    xfer(1'b1, tcs_pkg::OFF_SMC, {16'h0, r.sm}, W);
    xfer(1'b1, tcs_pkg::OFF_IEN, {16'h0, r.ie}, W);
    @(posedge hclk);
    pls[r.sel] <= 1'b1;
    @(posedge hclk);
    if (r.sel < 6) pls[r.sel] <= 1'b0;
    hits = 0;
    first = -1;
    for (int k = 0; k < 8; k++) begin
      @(posedge hclk);
      if (obs[r.obs] === 1'b1) begin
        hits++;
        if (first < 0) first = k;
      end
    end
    pls <= 11'h0;
    repeat (4) @(posedge hclk);
    chk(r.nm, r.exp, hits);
    $display("test %s done", r.nm);
  endtask

  // verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // table first, then timing, register and reset cases
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    xfer(1'b0, tcs_pkg::OFF_CTL1, 32'h0, W);
    chk("pulse_clear", 32'h8, rd);
    run_row(tcs_row_t'{"sync0",16'h0,16'h0,16'h4,16'h0,2'h0,6,7,1});
    lat0 = first;
    run_row(tcs_row_t'{"tout_late",16'h0,16'h0,16'h4,16'h0,2'h0,6,0,1});
    chk("tout_delay", lat0 + 1, first);
    run_row(tcs_row_t'{"sync1",16'h0,16'h0,16'h84,16'h0,2'h0,6,7,1});
    chk("sync_delay", lat0 + 1, first);
    run_row(tcs_row_t'{"trig",16'h0,16'h0,16'h6,16'h0,2'h0,6,6,1});
    chk("trig_run", 32'h1, {31'h0, obs[8]});
    xfer(1'b0, tcs_pkg::OFF_CTL1, 32'h0, W);
    chk("trig_run_bit", 32'h1, rd);
    xfer(1'b1, tcs_pkg::OFF_SMC, 32'h0, W);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'(i * 4), 32'hffffffff, W);
      xfer(1'b0, 8'(i * 4), 32'h0, W);
      chk("reg_mask", {16'h0, msk[i]}, rd);
    end
    xfer(1'b1, tcs_pkg::OFF_IEN, 32'h0, 3'h0);
    xfer(1'b1, 8'h0e, 32'h0, tcs_pkg::HSIZE_HALF);
    xfer(1'b0, tcs_pkg::OFF_IEN, 32'h0, W);
    chk("narrow_wr", 32'h47, rd);
    chk("bus_resp", 32'h0, {31'h0, hresp});
    xfer(1'b1, tcs_pkg::OFF_IEN, 32'h0, tcs_pkg::HSIZE_HALF);
    xfer(1'b0, tcs_pkg::OFF_CTL2, 32'h0, 3'h0);
    chk("byte_rd", 32'h70, rd);
    xfer(1'b0, tcs_pkg::OFF_IEN, 32'h0, W);
    chk("half_wr", 32'h0, rd);
    xfer(1'b1, 8'h10, 32'hffffffff, W);
    xfer(1'b0, 8'h10, 32'h0, W);
    chk("unmapped", 32'h0, rd);
    $display("test regs done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst_outs", 32'h0, {20'h0, obs});
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0, W);
      chk("rst_reg", 32'h0, rd);
    end
    $display("test reset done");
    end_sim();
  end
endmodule
